/* logic/cmx_ctrl.sv */
// Purpose: control logic of a two-wire channel mux with interrupt combine
// Assumes: SCL and SDA sampled by MCLK, far faster than the bus clock
// Notes: selection field of the register drives the channel enables
`timescale 1ns/1ps
// Behaviour
// - interrupt out low while any input low, except eight-channel and arbiter, which have no lanes
// - read bits 7..4 are inverted interrupt inputs
// - status and output follow inputs, nothing latched
// - two-channel parts have only interrupt lanes 0,1
// - status bits read-only, writes leave them alone
// - interrupt inputs readable as general inputs
// - new selection applied only at STOP
// - selection held until mux written again
// - power-up: none, eight-channel and arbiter channel 0
// - reset disconnects all channels on switches
// - reset selects channel 0 on eight-channel, arbiter
// - arbiter defaults to port zero, one by write
// - arbiter returns to zero by reset or write
// - write sets selection, read returns selection plus status
// - four-channel mux: bit 2 enables, bits 1..0 pick
module cmx_ctrl
   import cmx_pkg::*;
#(
   parameter cmx_variant_t VARIANT = CMX_MUX4
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // upstream bus, open-drain data
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_O,
   output logic SDA_OE,
   // address straps
   input wire logic [ADDR_PIN_W-1:0] ADDR_PIN,
   // interrupt inputs, one per downstream channel
   input wire logic [IRQ_W-1:0] IRQ_N,
   // combined interrupt, open-drain
   output logic INT_O,
   output logic INT_OE,
   // downstream channel enables
   output logic [CHAN_W-1:0] CHAN_EN
);
   localparam logic [3:0] SEL_RST = cmx_sel_reset(VARIANT);
   localparam logic [3:0] IRQ_MASK = cmx_irq_mask(VARIANT);

   logic [SYNC_W-1:0] sync_q;
   logic scl_d_r, sda_d_r;
   cmx_state_t state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] tx_r, tx_nxt;
   logic [SEL_W-1:0] pend_r, pend_nxt;
   logic pend_v_r, pend_v_nxt;
   logic rw_r, rw_nxt;
   logic ack_r, ack_nxt;
   logic [SEL_W-1:0] sel_r, sel_nxt;

   cmx_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk(MCLK),
      .rst_n(RST_N),
      .d_in({SCL_IN, SDA_IN, ADDR_PIN, IRQ_N}),
      .q_out(sync_q)
   );

   // decode of synchronised pins
   wire scl_s = sync_q[SYNC_W-1];
   wire sda_s = sync_q[SYNC_W-2];
   wire [ADDR_PIN_W-1:0] addr_s = sync_q[IRQ_W +: ADDR_PIN_W];
   wire [IRQ_W-1:0] irq_n_s = sync_q[IRQ_W-1:0];
   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   wire start_w = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire stop_w = scl_s & scl_d_r & ~sda_d_r & sda_s;
   wire [6:0] own_addr = {ADDR_PREFIX, addr_s};
   // live, unlatched, masked per variant
   wire [IRQ_W-1:0] irq_act = ~irq_n_s & IRQ_MASK;
   wire [7:0] rd_byte = {irq_act, sel_r};
   wire addr_hit = shift_r[7:1] == own_addr;

   // bus slave sequencing
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      tx_nxt = tx_r;
      pend_nxt = pend_r;
      pend_v_nxt = pend_v_r;
      rw_nxt = rw_r;
      ack_nxt = ack_r;
      if (stop_w)
      begin
         state_nxt = ST_IDLE;
         pend_v_nxt = 1'b0;
      end
      else if (start_w)
      begin
         // repeated start keeps the pending byte for the coming stop
         state_nxt = ST_ADDR;
         cnt_nxt = 4'h0;
      end
      else
      begin
         case (state_r)
            ST_ADDR, ST_WR:
               if (scl_rise)
               begin
                  shift_nxt = {shift_r[6:0], sda_s};
                  cnt_nxt = cnt_r + 4'h1;
               end
               else if (scl_fall && cnt_r == BYTE_BITS)
               begin
                  if (state_r == ST_WR)
                  begin
                     // low bits only; status bits are never written
                     pend_nxt = shift_r[SEL_W-1:0];
                     pend_v_nxt = 1'b1;
                     state_nxt = ST_WACK;
                  end
                  else if (addr_hit)
                  begin
                     rw_nxt = shift_r[0];
                     state_nxt = ST_AACK;
                  end
                  else
                     state_nxt = ST_IDLE;
               end
            ST_AACK:
               if (scl_fall)
               begin
                  cnt_nxt = 4'h0;
                  tx_nxt = rd_byte;
                  state_nxt = rw_r ? ST_RD : ST_WR;
               end
            ST_WACK:
               if (scl_fall)
               begin
                  cnt_nxt = 4'h0;
                  state_nxt = ST_WR;
               end
            ST_RD:
               if (scl_fall)
               begin
                  if (cnt_r == LAST_BIT)
                     state_nxt = ST_RACK;
                  else
                  begin
                     tx_nxt = {tx_r[6:0], 1'b0};
                     cnt_nxt = cnt_r + 4'h1;
                  end
               end
            ST_RACK:
               if (scl_rise)
                  ack_nxt = ~sda_s;
               else if (scl_fall)
               begin
                  cnt_nxt = 4'h0;
                  tx_nxt = rd_byte;
                  state_nxt = ack_r ? ST_RD : ST_IDLE;
               end
            ST_IDLE: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
         endcase
      end
   end

   // data line: ack slots and zero bits of the read byte
   wire drive_ack = (state_nxt == ST_AACK) || (state_nxt == ST_WACK);
   wire drive_rd = (state_nxt == ST_RD) && !tx_nxt[7];
   // selection moves only on stop, never on a repeated start
   assign sel_nxt = (stop_w && pend_v_r) ? pend_r : sel_r;

   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         pend_r <= SEL_RST_NONE;
         pend_v_r <= 1'b0;
         rw_r <= 1'b0;
         ack_r <= 1'b0;
      end
      else
      begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         tx_r <= tx_nxt;
         pend_r <= pend_nxt;
         pend_v_r <= pend_v_nxt;
         rw_r <= rw_nxt;
         ack_r <= ack_nxt;
      end
   end

   // selection and outputs
   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         sel_r <= SEL_RST;
         CHAN_EN <= 8'h00;
         SDA_O <= 1'b0;
         SDA_OE <= 1'b0;
         INT_O <= 1'b0;
         INT_OE <= 1'b0;
      end
      else
      begin
         sel_r <= sel_nxt;
         CHAN_EN <= cmx_chan_decode(VARIANT, sel_r);
         SDA_O <= 1'b0;
         SDA_OE <= drive_ack || drive_rd;
         INT_O <= 1'b0;
         INT_OE <= |irq_act;
      end
   end

   sequence s_commit;
      stop_w && pend_v_r;
   endsequence

   sequence s_addr_match;
      state_r == ST_ADDR && scl_fall && cnt_r == BYTE_BITS && addr_hit;
   endsequence

   a_int_low_any: assert property (
      @(posedge MCLK) disable iff (!RST_N) (|irq_act) |=> INT_OE)
      else $error("interrupt out not driven with an input low");

   a_int_release_all: assert property (
      @(posedge MCLK) disable iff (!RST_N) !(|irq_act) |=> !INT_OE)
      else $error("interrupt out held with all inputs high");

   // synchroniser holds its reset value for two edges after release
   a_status_live_bits: assert property (
      @(posedge MCLK) disable iff (!RST_N)
      $past(RST_N, 2) |->
      rd_byte[7:IRQ_LSB] == (~$past(IRQ_N, 2) & IRQ_MASK))
      else $error("status bits do not follow inverted inputs");

   a_two_lane_only: assert property (
      @(posedge MCLK) disable iff (!RST_N)
      (VARIANT == CMX_SWITCH2) |-> rd_byte[7:6] == 2'b00)
      else $error("unused interrupt lanes read as set");

   a_commit_stop_value: assert property (
      @(posedge MCLK) disable iff (!RST_N)
      s_commit |=> sel_r == $past(pend_r))
      else $error("pending selection not applied at stop");

   a_hold_no_stop: assert property (
      @(posedge MCLK) disable iff (!RST_N)
      !stop_w |=> $stable(sel_r))
      else $error("selection changed without a stop");

   a_reset_default_sel: assert property (
      @(posedge MCLK) disable iff (!RST_N)
      $rose(RST_N) |-> sel_r == SEL_RST ##2 CHAN_EN ==
      cmx_chan_decode(VARIANT, SEL_RST))
      else $error("reset default selection wrong");

   a_mux4_disable: assert property (
      @(posedge MCLK) disable iff (!RST_N)
      (VARIANT == CMX_MUX4 && !sel_r[MUX4_EN_BIT]) |=> CHAN_EN == 8'h00)
      else $error("channel open with enable bit clear");

   a_arb_port_one: assert property (
      @(posedge MCLK) disable iff (!RST_N)
      (VARIANT == CMX_ARB && sel_r[ARB_P1_BIT]) |=> CHAN_EN == 8'h02)
      else $error("port one not sole connection");

   a_ack_on_match: assert property (
      @(posedge MCLK) disable iff (!RST_N)
      s_addr_match |=> SDA_OE)
      else $error("own address not acknowledged");

endmodule

/* logic/cmx_pkg.sv */
// Purpose: shared constants, types and decode functions of the channel mux
// Assumes: one 8-bit control register reached over the two-wire bus
// Notes: variant picks channel decode, reset default and interrupt lanes
package cmx_pkg;

   // product variants
   typedef enum logic [2:0] {
      CMX_MUX4,
      CMX_SWITCH2,
      CMX_SWITCH4,
      CMX_MUX8,
      CMX_ARB
   } cmx_variant_t;

   // bus slave states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_AACK,
      ST_WR,
      ST_WACK,
      ST_RD,
      ST_RACK
   } cmx_state_t;

   // slave address: fixed prefix, low bits from strap pins
   localparam logic [3:0] ADDR_PREFIX = 4'hE;
   localparam int ADDR_PIN_W = 3;
   localparam int IRQ_W = 4;
   localparam int SEL_W = 4;
   localparam int CHAN_W = 8;
   localparam int SYNC_W = 2 + ADDR_PIN_W + IRQ_W;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;

   // control register fields
   localparam int IRQ_LSB = 4;
   localparam int MUX4_EN_BIT = 2;
   localparam int MUX8_EN_BIT = 3;
   localparam int ARB_P0_BIT = 0;
   localparam int ARB_P1_BIT = 1;

   // reset values of the selection field
   localparam logic [3:0] SEL_RST_NONE = 4'h0;
   localparam logic [3:0] SEL_RST_MUX8 = 4'h8;
   localparam logic [3:0] SEL_RST_ARB = 4'h1;

   // interrupt lanes per variant
   localparam logic [3:0] IRQ_MASK_TWO = 4'h3;
   localparam logic [3:0] IRQ_MASK_FOUR = 4'hF;
   localparam logic [3:0] IRQ_MASK_NONE = 4'h0;

   function automatic logic [3:0] cmx_irq_mask(cmx_variant_t v);
      logic [3:0] m;
      m = IRQ_MASK_NONE;
      case (v)
         CMX_SWITCH2: m = IRQ_MASK_TWO;
         CMX_MUX4: m = IRQ_MASK_FOUR;
         CMX_SWITCH4: m = IRQ_MASK_FOUR;
         default: m = IRQ_MASK_NONE;
      endcase
      return m;
   endfunction

   function automatic logic [3:0] cmx_sel_reset(cmx_variant_t v);
      logic [3:0] r;
      r = SEL_RST_NONE;
      case (v)
         CMX_MUX8: r = SEL_RST_MUX8;
         CMX_ARB: r = SEL_RST_ARB;
         default: r = SEL_RST_NONE;
      endcase
      return r;
   endfunction

   // arbiter: port one wins when both enables are written
   function automatic logic [7:0] cmx_chan_decode(cmx_variant_t v,
                                                  logic [3:0] s);
      logic [7:0] r;
      r = 8'h00;
      case (v)
         CMX_MUX4:
            if (s[MUX4_EN_BIT])
               r[s[1:0]] = 1'b1;
         CMX_MUX8:
            if (s[MUX8_EN_BIT])
               r[s[2:0]] = 1'b1;
         CMX_ARB:
            if (s[ARB_P1_BIT])
               r[1] = 1'b1;
            else if (s[ARB_P0_BIT])
               r[0] = 1'b1;
         CMX_SWITCH2: r[1:0] = s[1:0];
         default: r[3:0] = s;
      endcase
      return r;
   endfunction

endpackage

/* logic/cmx_sync.sv */
// Purpose: two-stage synchroniser for pins entering the MCLK domain
// Assumes: synchronous active-low reset, idle level high
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module cmx_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins in, synchronised out
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_r <= '1;
         q_out <= '1;
      end
      else
      begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule

/* test/cmx_master.sv */
// Purpose: upstream two-wire bus master driving the mux control slave
// Assumes: pull-up on data resolved by the bench, scl idles high
// Notes: quarter bit of Q mclk; Q below 2 outruns the slave's 3-clock lag
`timescale 1ns/1ps
module cmx_master #(
   parameter int Q = 2
) (
   // clock
   input wire logic mclk,
   // bus wires
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // start or repeated start
   task automatic start();
      sda_low <= 1'b0;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      sda_low <= 1'b1;
      tick(Q);
      scl <= 1'b0;
      tick(Q);
   endtask

   task automatic stop();
      sda_low <= 1'b1;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      sda_low <= 1'b0;
      tick(2 * Q);
   endtask

   // eight bits msb first, then the ack bit
   task automatic byte_io(input logic [7:0] d, input logic ack_in,
                          output logic [7:0] q, output logic ack_out);
      logic [8:0] v;
      v = {d, ack_in};
      for (int i = 8; i >= 0; i--)
      begin
         sda_low <= !v[i];
         tick(Q);
         scl <= 1'b1;
         tick(Q);
         if (i > 0)
            q[i-1] = sda;
         else
            ack_out = sda;
         tick(Q);
         scl <= 1'b0;
         tick(Q);
      end
   endtask

   // address, selection byte, then stop before downstream use
   task automatic write_sel(input logic [6:0] a, input logic [7:0] d,
                            input logic do_stop, output logic ok);
      logic [7:0] q;
      logic a1;
      logic a2;
      start();
      byte_io({a, 1'b0}, 1'b1, q, a1);
      byte_io(d, 1'b1, q, a2);
      ok = !a1 && !a2;
      if (do_stop)
         stop();
   endtask

   // one byte read, master nack ends it
   task automatic read_reg(input logic [6:0] a, input logic do_stop,
                           output logic [7:0] q, output logic ok);
      logic [7:0] x;
      logic a1;
      logic a2;
      start();
      byte_io({a, 1'b1}, 1'b1, x, a1);
      byte_io(8'hFF, 1'b1, q, a2);
      ok = !a1;
      if (do_stop)
         stop();
   endtask
endmodule

/* test/cmx_ctrl_test.sv */
// Purpose: self-checking bench of the channel mux control
// Assumes: strap pins fixed, master model owns the bus pins
// Notes: four variants share one bus, each on its own strap
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         $display("Error %s expected %h seen %h", nm, exp, got); \
         n_errors++; \
      end \
   end
module cmx_ctrl_test;
   import cmx_pkg::*;
   localparam logic [6:0] DEV = {ADDR_PREFIX, 3'h5};
   localparam logic [6:0] DEV_M8 = {ADDR_PREFIX, 3'h4};
   localparam logic [6:0] DEV_ARB = {ADDR_PREFIX, 3'h6};
   localparam logic [6:0] DEV_SW2 = {ADDR_PREFIX, 3'h7};
   logic mclk, rst_n, scl, sda_low, sda, sda_o, sda_oe;
   logic int_o, int_oe, int_w, ok;
   logic [IRQ_W-1:0] irq_n;
   logic [CHAN_W-1:0] chan_en, chan_m8, chan_arb, chan_sw2;
   logic [7:0] rd;
   // lane 0 eight-channel, 1 arbiter, 2 two-channel switch
   wire [2:0] x_sda_o, x_sda_oe, x_int_o, x_int_oe;
   wire [2:0] int_x;
   int n_errors = 0;
   int checks_done = 0;

   // open-drain wires with pull-ups
   assign sda = (sda_low || (sda_oe && !sda_o) ||
                 |(x_sda_oe & ~x_sda_o)) ? 1'b0 : 1'b1;
   assign int_w = (int_oe && !int_o) ? 1'b0 : 1'b1;
   assign int_x = ~(x_int_oe & ~x_int_o);

   cmx_ctrl #(.VARIANT(CMX_MUX4)) dut_u (.MCLK(mclk), .RST_N(rst_n),
      .SCL_IN(scl), .SDA_IN(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
      .ADDR_PIN(3'h5), .IRQ_N(irq_n), .INT_O(int_o), .INT_OE(int_oe),
      .CHAN_EN(chan_en));

   cmx_ctrl #(.VARIANT(CMX_MUX8)) m8_u (.MCLK(mclk), .RST_N(rst_n),
      .SCL_IN(scl), .SDA_IN(sda), .SDA_O(x_sda_o[0]),
      .SDA_OE(x_sda_oe[0]), .ADDR_PIN(3'h4), .IRQ_N(irq_n),
      .INT_O(x_int_o[0]), .INT_OE(x_int_oe[0]), .CHAN_EN(chan_m8));

   cmx_ctrl #(.VARIANT(CMX_ARB)) arb_u (.MCLK(mclk), .RST_N(rst_n),
      .SCL_IN(scl), .SDA_IN(sda), .SDA_O(x_sda_o[1]),
      .SDA_OE(x_sda_oe[1]), .ADDR_PIN(3'h6), .IRQ_N(irq_n),
      .INT_O(x_int_o[1]), .INT_OE(x_int_oe[1]), .CHAN_EN(chan_arb));

   cmx_ctrl #(.VARIANT(CMX_SWITCH2)) sw2_u (.MCLK(mclk), .RST_N(rst_n),
      .SCL_IN(scl), .SDA_IN(sda), .SDA_O(x_sda_o[2]),
      .SDA_OE(x_sda_oe[2]), .ADDR_PIN(3'h7), .IRQ_N(irq_n),
      .INT_O(x_int_o[2]), .INT_OE(x_int_oe[2]), .CHAN_EN(chan_sw2));

   // 200 ns link clock
   cmx_master #(.Q(2)) bus_u (.mclk(mclk), .sda(sda), .scl(scl),
      .sda_low(sda_low));

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic t_reset();
      `CHK("chan_en", 8'h00, chan_en)
      `CHK("chan_m8", 8'h01, chan_m8)
      `CHK("chan_arb", 8'h01, chan_arb)
      `CHK("chan_sw2", 8'h00, chan_sw2)
      `CHK("int_w", 1'b1, int_w)
      bus_u.read_reg(DEV, 1'b1, rd, ok);
      `CHK("reg", 8'h00, rd)
      bus_u.read_reg(DEV_ARB, 1'b1, rd, ok);
      `CHK("arb reg", 8'h01, rd)
      $display("test reset done");
   endtask

   task automatic t_irq();
      for (int i = 0; i < 4; i++)
      begin
         irq_n <= ~(4'h1 << i);
         idle(8);
         `CHK("int_w", 1'b0, int_w)
         bus_u.read_reg(DEV, 1'b1, rd, ok);
         `CHK("status", 8'h10 << i, rd)
         irq_n <= 4'hF;
         idle(8);
         `CHK("int_w", 1'b1, int_w)
      end
      // two low, one lifted: output stays low
      irq_n <= 4'h6;
      idle(8);
      irq_n <= 4'h7;
      idle(8);
      `CHK("int_w", 1'b0, int_w)
      irq_n <= 4'hF;
      idle(8);
      bus_u.read_reg(DEV, 1'b1, rd, ok);
      `CHK("status", 8'h00, rd)
      $display("test irq done");
   endtask

   task automatic t_select();
      for (int c = 0; c < 4; c++)
      begin
         bus_u.write_sel(DEV, 8'h04 | 8'(c), 1'b1, ok);
         `CHK("ack", 1'b1, ok)
         idle(8);
         `CHK("chan_en", 8'h01 << c, chan_en)
         bus_u.read_reg(DEV, 1'b1, rd, ok);
         `CHK("reg", 8'h04 | 8'(c), rd)
      end
      // enable bit clear: nothing connected
      bus_u.write_sel(DEV, 8'h03, 1'b1, ok);
      idle(8);
      `CHK("chan_en", 8'h00, chan_en)
      $display("test select done");
   endtask

   task automatic t_restart();
      bus_u.write_sel(DEV, 8'h06, 1'b1, ok);
      idle(8);
      irq_n <= 4'hE;
      bus_u.write_sel(DEV, 8'hF5, 1'b0, ok);
      bus_u.read_reg(DEV, 1'b0, rd, ok);
      `CHK("chan_en", 8'h04, chan_en)
      `CHK("reg", 8'h16, rd)
      bus_u.stop();
      idle(8);
      `CHK("chan_en", 8'h02, chan_en)
      bus_u.read_reg(DEV, 1'b1, rd, ok);
      `CHK("reg", 8'h15, rd)
      irq_n <= 4'hF;
      $display("test restart done");
   endtask

   task automatic t_other();
      // traffic for a downstream device leaves selection alone
      bus_u.write_sel(7'h23, 8'h04, 1'b1, ok);
      `CHK("ack", 1'b0, ok)
      idle(8);
      `CHK("chan_en", 8'h02, chan_en)
      $display("test other done");
   endtask

   task automatic t_lanes();
      // lanes 2 and 3 do not exist on the two-channel switch
      irq_n <= 4'h3;
      idle(8);
      `CHK("int_sw2", 1'b1, int_x[2])
      bus_u.read_reg(DEV_SW2, 1'b1, rd, ok);
      `CHK("sw2 status", 8'h00, rd)
      irq_n <= 4'hD;
      idle(8);
      `CHK("int_sw2", 1'b0, int_x[2])
      bus_u.read_reg(DEV_SW2, 1'b1, rd, ok);
      `CHK("sw2 status", 8'h20, rd)
      irq_n <= 4'hF;
      bus_u.write_sel(DEV_SW2, 8'h03, 1'b1, ok);
      bus_u.write_sel(DEV_M8, 8'h0F, 1'b1, ok);
      idle(8);
      `CHK("chan_sw2", 8'h03, chan_sw2)
      `CHK("chan_m8", 8'h80, chan_m8)
      `CHK("chan_en", 8'h02, chan_en)
      $display("test lanes done");
   endtask

   task automatic t_arb();
      bus_u.write_sel(DEV_ARB, 8'h02, 1'b1, ok);
      `CHK("ack", 1'b1, ok)
      idle(8);
      `CHK("chan_arb", 8'h02, chan_arb)
      // give up port one by a write
      bus_u.write_sel(DEV_ARB, 8'h01, 1'b1, ok);
      idle(8);
      `CHK("chan_arb", 8'h01, chan_arb)
      bus_u.write_sel(DEV_ARB, 8'h02, 1'b1, ok);
      idle(8);
      `CHK("chan_arb", 8'h02, chan_arb)
      // then by a reset pulse, bus idle
      rst_n <= 1'b0;
      idle(4);
      rst_n <= 1'b1;
      idle(6);
      `CHK("chan_arb", 8'h01, chan_arb)
      `CHK("chan_m8", 8'h01, chan_m8)
      `CHK("chan_sw2", 8'h00, chan_sw2)
      $display("test arb done");
   endtask

   initial
   begin
      repeat (100000) @(posedge mclk);
      n_errors++;
      $display("Error watchdog expected done seen hang");
      finish_test();
   end

   initial
   begin
      rst_n = 1'b0;
      irq_n = 4'hF;
      idle(4);
      rst_n <= 1'b1;
      idle(6);
      t_reset();
      t_irq();
      t_select();
      t_restart();
      t_other();
      t_lanes();
      t_arb();
      finish_test();
   end
endmodule
